/* sim/capture_compare_pwm_control_test.sv */
/*
  capture_compare_pwm_control_test: drives registers over Wishbone and checks.
  assumes: ccp_top, ccp_far_model and the checker are compiled before it.
*/
`timescale 1ns/1ps
module capture_compare_pwm_control_test;
  import ccp_pkg::*;
  logic sys_clk, reset, cyc, stb, we, wb_ack_o, irq, hold, load;
  logic [13:0] adr;
  logic [31:0] dw, wb_dat_o, q;
  logic [15:0] lval, v;
  logic [3:0] src;
  logic [9:0] d;
  logic [7:0] lo, r;
  logic [2:0] cc_clr, pt_clr;
  logic [1:0] ch_out, pwm_o;
  logic [15:0] tmr [3];
  logic [7:0] pcnt [3], lim [3];
  logic [1:0] plow [3];
  logic [3:0] cc [8];
  int n_mismatch, comparisons, n, e, hi, p;
  ccp_top u_dut (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .timer_one(tmr[0]), .timer_three(tmr[1]), .timer_five(tmr[2]),
    .period_timer_count(pcnt), .period_timer_low(plow), .period_timer_tick(3'h7),
    .period_limit(lim), .input_pin({1'b0, src[0]}), .comparator_one_result(src[1]),
    .comparator_two_result(src[2]), .pin_change_event(src[3]), .cc_timer_clear(cc_clr),
    .period_timer_clear(pt_clr), .channel_out(ch_out), .pwm_out(pwm_o), .irq(irq));
  ccp_far_model u_far (.sys_clk(sys_clk), .reset(reset), .hold(hold), .load(load),
    .load_val(lval), .cc_timer_clear(cc_clr), .period_timer_clear(pt_clr), .tmr(tmr),
    .pcnt(pcnt), .plow(plow));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bad(input string m);
    n_mismatch++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] x, input string m);
    comparisons++;
    if (g !== x) bad(m);
  endtask
  task automatic chk_int(input int g, input int x, input string m);
    comparisons++;
    if (g != x) bad(m);
  endtask
  // request held until a rising edge samples ack high, released at that edge
  task automatic wb(input logic w, input logic [11:0] idx, input logic [31:0] dat);
    int k;
    k = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    dw <= dat;
    do begin
      @(posedge sys_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20 && wb_ack_o !== 1'b1) begin
      bad("bus timeout");
      wrap_up();
    end
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic pulse(input int s, input logic l);
    @(posedge sys_clk);
    src[s] <= l;
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic flag(output int f);
    wb(1'b0, CCP_IRQ_STAT, 32'h0);
    f = int'(q[0] === 1'b1);
    if (f != 0) wb(1'b1, CCP_IRQ_STAT, 32'h1);
  endtask
  task automatic tload(input logic [15:0] t);
    @(posedge sys_clk);
    lval <= t;
    load <= 1'b1;
    @(posedge sys_clk);
    load <= 1'b0;
  endtask
  task automatic meas(input int w, input int per, output int h);
    h = 0;
    repeat (per) begin
      @(negedge sys_clk);
      h += int'((w == 0 ? ch_out[0] : pwm_o[w-1]) === 1'b1);
    end
  endtask
  initial begin
    void'($urandom(3249));
    {reset, hold} = 2'h3;
    {cyc, stb, we, load} = 4'h0;
    {adr, dw, src, lval} = '0;
    lim = '{8'hFF, 8'hFF, 8'hFF};
    cc = '{4'h8, 4'h9, 4'h2, 4'h9, 4'h1, 4'h9, 4'hA, 4'hB};
    n_mismatch = 0;
    comparisons = 0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    wb(1'b0, CCP_TMR_BIND, 32'h0);
    chk_reg(q, 32'h55, "binding reset");
    wb(1'b0, CCP_CH1_CTRL, 32'h0);
    chk_reg(q, 32'h0, "control reset");
    wb(1'b1, 12'hFB5, 32'hFF);
    wb(1'b0, 12'hFB5, 32'h0);
    chk_reg(q, 32'h0, "unmapped read");
    r = $urandom;
    wb(1'b1, CCP_TMR_BIND, {24'h0, r});
    wb(1'b0, CCP_TMR_BIND, 32'h0);
    chk_reg(q, {24'h0, r}, "binding rw");
    wb(1'b1, CCP_TMR_BIND, 32'h55);
    for (int m = 3; m < 8; m++) begin
      v = $urandom;
      tload(v);
      wb(1'b1, CCP_CH1_CTRL, 32'h80 | m);
      n = 0;
      repeat (16) for (int s = 1; s >= 0; s--) begin
        pulse(0, s[0]);
        flag(e);
        n += e;
      end
      chk_int(n, m == 3 ? 32 : m < 6 ? 16 : m == 6 ? 4 : 1, "capture count");
      wb(1'b0, CCP_CH1_VAL_LO, 32'h0);
      lo = q[7:0];
      wb(1'b0, CCP_CH1_VAL_HI, 32'h0);
      chk_reg({16'h0, q[7:0], lo}, {16'h0, v}, "captured value");
      wb(1'b1, CCP_CH1_CTRL, 32'h0);
    end
    wb(1'b1, CCP_CH1_CTRL, 32'h85);
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, CCP_CH1_TRIG, c);
      pulse((c + 1) % 4, 1'b1);
      pulse((c + 1) % 4, 1'b0);
      flag(e);
      chk_int(e, 0, "other source");
      pulse(c, 1'b1);
      pulse(c, 1'b0);
      flag(e);
      chk_int(e, 1, "chosen source");
    end
    wb(1'b1, CCP_IRQ_MASK, 32'h1);
    pulse(3, 1'b1);
    chk_reg({31'h0, irq}, 32'h1, "irq raised");
    wb(1'b1, CCP_IRQ_MASK, 32'h0);
    @(negedge sys_clk);
    chk_reg({31'h0, irq}, 32'h0, "irq masked");
    wb(1'b1, CCP_IRQ_STAT, 32'h1);
    wb(1'b1, CCP_IRQ_MASK, 32'h1);
    @(negedge sys_clk);
    chk_reg({31'h0, irq}, 32'h0, "irq cleared");
    pulse(3, 1'b0);
    wb(1'b1, CCP_IRQ_MASK, 32'h0);
    // channel two captures on comparator one, flag bit 1
    wb(1'b1, CCP_CH2_TRIG, 32'h1);
    wb(1'b1, CCP_CH2_CTRL, 32'h85);
    pulse(1, 1'b1);
    pulse(1, 1'b0);
    wb(1'b0, CCP_IRQ_STAT, 32'h0);
    chk_reg(q & 32'h3, 32'h2, "channel two flag");
    wb(1'b0, CCP_CH2_VAL_LO, 32'h0);
    chk_reg(q, {24'h0, tmr[0][7:0]}, "channel two value");
    wb(1'b1, CCP_CH2_CTRL, 32'h0);
    // hi byte differs per pass so a half-written value never matches
    for (int i = 0; i < 8; i++) begin
      v = {8'h10 + 8'(i), 8'h03 + 8'($urandom % 250)};
      tload(v - 16'h0003);
      wb(1'b1, CCP_CH1_VAL_LO, {24'h0, v[7:0]});
      wb(1'b1, CCP_CH1_VAL_HI, {24'h0, v[15:8]});
      wb(1'b1, CCP_CH1_CTRL, {24'h8, cc[i]});
      @(posedge sys_clk);
      hold <= 1'b0;
      repeat (10) @(posedge sys_clk);
      hold <= 1'b1;
      flag(e);
      chk_int(e, 1, "match flag");
      wb(1'b0, CCP_CH1_CTRL, 32'h0);
      e = int'(cc[i] == 4'h8 || cc[i][3:2] == 2'h0);
      chk_reg(q, {24'h0, 2'h2, e[0], 1'b0, cc[i]}, "output level");
      chk_int(int'(tmr[0] < 16'h0010), int'(cc[i] == 4'h1 || cc[i] == 4'hB), "clear");
      if (cc[i] == 4'h8) begin
        wb(1'b1, CCP_CH1_CTRL, 32'h08);
        @(negedge sys_clk);
        chk_reg({31'h0, ch_out[0]}, 32'h0, "latch reset");
      end
    end
    for (int f = 0; f < 2; f++) begin
      p = 8 + $urandom % 24;
      lim[0] <= 8'(p);
      d = 10'(1 + $urandom % (4 * p + 3));
      r = $urandom;
      wb(1'b1, CCP_CH1_VAL_HI, {24'h0, f ? d[9:2] : {r[7:2], d[9:8]}});
      wb(1'b1, CCP_CH1_VAL_LO, {24'h0, f ? {d[1:0], r[5:0]} : d[7:0]});
      wb(1'b1, CCP_CH1_CTRL, f ? 32'h9F : 32'h8C);
      repeat (1200) @(posedge sys_clk);
      meas(0, 4 * (p + 1), hi);
      chk_int(hi, d, "pwm width");
      flag(e);
      chk_int(e, 1, "pwm flag");
    end
    wb(1'b1, CCP_TMR_BIND, 32'hE5);
    for (int k = 0; k < 2; k++) begin
      p = 8 + $urandom % 24;
      lim[k+1] <= 8'(p);
      d = 10'(1 + $urandom % (4 * p + 3));
      wb(1'b1, k ? CCP_PWM_DUTY4 : CCP_PWM_DUTY3, {16'h0, d[1:0], 6'h0, d[9:2]});
      repeat (1200) @(posedge sys_clk);
      meas(k + 1, 4 * (p + 1), hi);
      chk_int(hi, d, "plain pwm width");
    end
    wrap_up();
  end
endmodule // capture_compare_pwm_control_test

/* sim/ccp_chk.sv */
/*
  ccp_chk: port assertions for the capture/compare/PWM block.
  assumes: bound into ccp_top; one clock, synchronous reset.
*/
`timescale 1ns/1ps
module ccp_chk #(
  parameter int NCH = 2
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [7:0] period_timer_count [3],
  input wire logic [1:0] period_timer_low [3],
  input wire logic [2:0] period_timer_tick,
  input wire logic [7:0] period_limit [3],
  input wire logic [2:0] cc_timer_clear,
  input wire logic [2:0] period_timer_clear,
  input wire logic [NCH-1:0] channel_out,
  input wire logic [1:0] pwm_out,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_wrap(int i);
    disable iff (reset) period_timer_clear[i] |-> period_timer_tick[i] &&
      period_timer_count[i] == period_limit[i] && period_timer_low[i] == 2'h3;
  endproperty
  AST_WB_ACK: assert property (disable iff (reset) s_req |=> s_ack_pulse)
    else $error("ack not a single pulse after request");
  AST_WB_CAUSE: assert property (disable iff (reset)
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  AST_RST_QUIET: assert property (reset |=> !wb_ack_o && !irq &&
    channel_out == '0 && pwm_out == 2'h0) else $error("outputs active after reset");
  AST_WRAP_T2: assert property (p_wrap(0)) else $error("timer two clear off wrap");
  AST_WRAP_T4: assert property (p_wrap(1)) else $error("timer four clear off wrap");
  AST_WRAP_T6: assert property (p_wrap(2)) else $error("timer six clear off wrap");
  AST_PWM_RISE: assert property (disable iff (reset) $rose(pwm_out[0]) |->
    $past(|period_timer_clear) || $past(|period_timer_clear, 2)) else $error("pwm rose off wrap");
  AST_CC_CLR_ONE: assert property (disable iff (reset)
    |cc_timer_clear |=> cc_timer_clear == 3'h0) else $error("timer clear held");
endmodule // ccp_chk

bind ccp_top ccp_chk #(.NCH(NCH)) u_chk (.sys_clk(sys_clk), .reset(reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .period_timer_count(period_timer_count), .period_timer_low(period_timer_low),
  .period_timer_tick(period_timer_tick), .period_limit(period_limit),
  .cc_timer_clear(cc_timer_clear), .period_timer_clear(period_timer_clear),
  .channel_out(channel_out), .pwm_out(pwm_out), .irq(irq));

/* sim/ccp_far_model.sv */
/*
  ccp_far_model: timers one/three/five and period timers two/four/six.
  assumes: bench drives hold and load; clears come from the block.
*/
`timescale 1ns/1ps
module ccp_far_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic hold,
  input wire logic load,
  input wire logic [15:0] load_val,
  input wire logic [2:0] cc_timer_clear,
  input wire logic [2:0] period_timer_clear,
  output logic [15:0] tmr [3],
  output logic [7:0] pcnt [3],
  output logic [1:0] plow [3]
);
  // period timers tick every cycle, so one base step is one clock
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (reset || cc_timer_clear[i]) begin
        tmr[i] <= 16'h0000;
      end else if (load) begin
        tmr[i] <= load_val;
      end else if (!hold) begin
        tmr[i] <= tmr[i] + 16'h0001;
      end
      if (reset || period_timer_clear[i]) begin
        pcnt[i] <= 8'h00;
        plow[i] <= 2'h0;
      end else begin
        plow[i] <= plow[i] + 2'h1;
        pcnt[i] <= pcnt[i] + {7'h00, plow[i] == 2'h3};
      end
    end
  end
endmodule // ccp_far_model

/* src/ccp_edge.sv */
/*
  ccp_edge: two-flop synchroniser and edge detector for one capture source.
  assumes: input is asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module ccp_edge (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;
endmodule // ccp_edge

/* src/ccp_pkg.sv */
/*
  ccp_pkg: register offsets, field positions, reset values and mode codes
  for the capture/compare/PWM control block.
  assumes: byte offsets are register indices; bus byte address = 4 * index.
*/
package ccp_pkg;
  // register indices as printed; value registers split into low/high bytes
  localparam logic [11:0] CCP_CH2_VAL_LO = 12'hFA6;
  localparam logic [11:0] CCP_CH2_VAL_HI = 12'hFA7;
  localparam logic [11:0] CCP_CH2_CTRL = 12'hFA8;
  localparam logic [11:0] CCP_CH2_TRIG = 12'hFA9;
  localparam logic [11:0] CCP_CH1_VAL_LO = 12'hFAA;
  localparam logic [11:0] CCP_CH1_VAL_HI = 12'hFAB;
  localparam logic [11:0] CCP_CH1_CTRL = 12'hFAC;
  localparam logic [11:0] CCP_CH1_TRIG = 12'hFAD;
  localparam logic [11:0] CCP_TMR_BIND = 12'hFAE;
  localparam logic [11:0] CCP_IRQ_STAT = 12'hFB0;
  localparam logic [11:0] CCP_IRQ_MASK = 12'hFB1;
  localparam logic [11:0] CCP_PWM_DUTY3 = 12'hFB2;
  localparam logic [11:0] CCP_PWM_DUTY4 = 12'hFB3;
  localparam int CCP_ADDR_LSB = 2;
  // control register fields
  localparam int CCP_EN_BIT = 7;
  localparam int CCP_OUT_BIT = 5;
  localparam int CCP_FMT_BIT = 4;
  localparam logic [7:0] CCP_TMR_BIND_RST = 8'h55;
  localparam logic [7:0] CCP_CTRL_RST = 8'h00;
  localparam logic [1:0] CCP_TSEL_RSVD = 2'h0;
  // mode codes
  localparam logic [3:0] CCP_M_OFF = 4'h0;
  localparam logic [3:0] CCP_M_TOG_CLR = 4'h1;
  localparam logic [3:0] CCP_M_TOG = 4'h2;
  localparam logic [3:0] CCP_M_CAP_ANY = 4'h3;
  localparam logic [3:0] CCP_M_CAP_FALL = 4'h4;
  localparam logic [3:0] CCP_M_CAP_RISE = 4'h5;
  localparam logic [3:0] CCP_M_CAP_R4 = 4'h6;
  localparam logic [3:0] CCP_M_CAP_R16 = 4'h7;
  localparam logic [3:0] CCP_M_SET = 4'h8;
  localparam logic [3:0] CCP_M_CLR = 4'h9;
  localparam logic [3:0] CCP_M_PULSE = 4'hA;
  localparam logic [3:0] CCP_M_PULSE_CLR = 4'hB;
  localparam logic [1:0] CCP_PWM_HI = 2'h3;
  localparam logic [3:0] CCP_PRESC_4 = 4'h3;
  localparam logic [3:0] CCP_PRESC_16 = 4'hF;
  typedef enum logic [1:0] {CCP_CLS_OFF, CCP_CLS_CAP, CCP_CLS_CMP, CCP_CLS_PWM} ccp_cls_t;
endpackage

/* src/ccp_pwm.sv */
/*
  ccp_pwm: 10-bit PWM engine on an 8-bit period timer plus two low bits.
  assumes: timer count, period limit and increment pulse come from the
  selected timer on sys_clk; tick marks each increment of the 10-bit base.
*/
`timescale 1ns/1ps
module ccp_pwm
  import ccp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic tick,
  input wire logic [7:0] tmr_cnt,
  input wire logic [1:0] tmr_low,
  input wire logic [7:0] period,
  input wire logic [9:0] duty,
  output logic pwm_out,
  output logic period_evt
);
  logic [9:0] duty_buf_r;
  logic out_r;
  logic wrap;
  // wrap happens on the increment taken while count equals limit and the low bits are 3
  assign wrap = tick && tmr_cnt == period && tmr_low == 2'h3;
  assign period_evt = run && wrap;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      duty_buf_r <= 10'h000;
    end else if (period_evt) begin
      duty_buf_r <= duty;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset || !run) begin
      out_r <= 1'b0;
    end else if (wrap) begin
      out_r <= duty != 10'h000;
    end else if (tick && {tmr_cnt, tmr_low} + 10'h001 == duty_buf_r) begin
      // drops as the base steps onto the width, so high for width steps
      out_r <= 1'b0;
    end
  end
  assign pwm_out = out_r;
endmodule // ccp_pwm

/* src/ccp_top.sv */
/*
  ccp_top: two capture/compare/PWM channels, two plain PWM channels, timer
  binding select, interrupt status/mask, classic Wishbone slave.
  assumes: timers, comparators, pin-change logic live outside; timer values
  and tick pulses are on sys_clk; pins and comparator outputs are async.
*/
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module ccp_top
  import ccp_pkg::*;
#(
  parameter int NCH = 2
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] timer_one,
  input wire logic [15:0] timer_three,
  input wire logic [15:0] timer_five,
  input wire logic [7:0] period_timer_count [3],
  input wire logic [1:0] period_timer_low [3],
  input wire logic [2:0] period_timer_tick,
  input wire logic [7:0] period_limit [3],
  input wire logic [NCH-1:0] input_pin,
  input wire logic comparator_one_result,
  input wire logic comparator_two_result,
  input wire logic pin_change_event,
  output logic [2:0] cc_timer_clear,
  output logic [2:0] period_timer_clear,
  output logic [NCH-1:0] channel_out,
  output logic [1:0] pwm_out,
  output logic irq
);
  // register map and clear wiring are laid out for two channels only
  if (NCH != 2) begin : g_nch_chk
    $error("ccp_top supports exactly two channels");
  end
  // index is twelve bits of a fourteen-bit byte address
  if (CCP_ADDR_LSB != 2) begin : g_lsb_chk
    $error("ccp_top expects four-byte register spacing");
  end

  logic [7:0] ctrl_r [NCH];
  logic [1:0] trig_r [NCH];
  logic [15:0] val_r [NCH];
  logic [7:0] bind_r;
  logic [9:0] pduty_r [2];
  logic [3:0] stat_r;
  logic [3:0] mask_r;
  logic [3:0] evt;
  logic [NCH-1:0] ch_out_r;
  logic wr;
  logic rd_ok;
  logic [11:0] idx;
  logic [31:0] rd_nxt;
  logic cmp1_lvl;
  logic cmp2_lvl;
  logic cmp1_rise;
  logic cmp2_rise;
  logic cmp1_fall;
  logic cmp2_fall;
  logic pc_rise;
  logic [2:0] cc_clr_nxt;
  logic [2:0] pt_clr_nxt;

  // sel[0] gates every write; lanes 2-3 carry no register, lane 1 only duty bits 15:14
  assign idx = wb_adr_i[13:CCP_ADDR_LSB];
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

  // comparator and pin-change sources are shared by both channels
  ccp_edge u_cmp1 (.sys_clk(sys_clk), .reset(reset), .async_in(comparator_one_result),
    .level(cmp1_lvl), .rise(cmp1_rise), .fall(cmp1_fall));
  ccp_edge u_cmp2 (.sys_clk(sys_clk), .reset(reset), .async_in(comparator_two_result),
    .level(cmp2_lvl), .rise(cmp2_rise), .fall(cmp2_fall));
  ccp_edge u_pc (.sys_clk(sys_clk), .reset(reset), .async_in(pin_change_event),
    .level(), .rise(pc_rise), .fall());

  // binding and plain PWM duty registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bind_r <= CCP_TMR_BIND_RST;
      pduty_r[0] <= 10'h000;
      pduty_r[1] <= 10'h000;
    end else if (wr) begin
      if (idx == CCP_TMR_BIND) bind_r <= wb_dat_i[7:0];
      if (idx == CCP_PWM_DUTY3) pduty_r[0] <= {wb_dat_i[7:0], wb_dat_i[15:14]};
      if (idx == CCP_PWM_DUTY4) pduty_r[1] <= {wb_dat_i[7:0], wb_dat_i[15:14]};
    end
  end

  // interrupt status and mask; hardware set wins over write-one clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stat_r <= 4'h0;
      mask_r <= 4'h0;
    end else begin
      stat_r <= (stat_r & ~((wr && idx == CCP_IRQ_STAT) ? wb_dat_i[3:0] : 4'h0)) | evt;
      if (wr && idx == CCP_IRQ_MASK) mask_r <= wb_dat_i[3:0];
    end
  end
  assign irq = |(stat_r & mask_r);

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [11:0] i_ctrl;
      logic [11:0] i_trig;
      logic [11:0] i_lo;
      logic [11:0] i_hi;
      logic [1:0] tsel;
      logic [3:0] mode;
      logic en;
      ccp_cls_t cls;
      logic pin_lvl;
      logic pin_rise;
      logic pin_fall;
      logic s_rise;
      logic s_fall;
      logic [3:0] presc_r;
      logic cap_hit;
      logic [15:0] tval;
      logic match;
      logic match_seen_r;
      logic pulse_r;
      logic pwm_lvl;
      logic pwm_evt;
      logic [9:0] width;
      logic ctrl_wr;
      assign i_ctrl = (g == 0) ? CCP_CH1_CTRL : CCP_CH2_CTRL;
      assign i_trig = (g == 0) ? CCP_CH1_TRIG : CCP_CH2_TRIG;
      assign i_lo = (g == 0) ? CCP_CH1_VAL_LO : CCP_CH2_VAL_LO;
      assign i_hi = (g == 0) ? CCP_CH1_VAL_HI : CCP_CH2_VAL_HI;
      assign tsel = bind_r[2*g +: 2];
      assign mode = ctrl_r[g][3:0];
      assign en = ctrl_r[g][CCP_EN_BIT] && tsel != CCP_TSEL_RSVD;
      assign ctrl_wr = wr && idx == i_ctrl;

      // reserved binding code counts as a disabled channel
      always_comb begin
        if (!en || mode == CCP_M_OFF) cls = CCP_CLS_OFF;
        else if (mode[3:2] == CCP_PWM_HI) cls = CCP_CLS_PWM;
        else if (mode >= CCP_M_CAP_ANY && mode <= CCP_M_CAP_R16) cls = CCP_CLS_CAP;
        else cls = CCP_CLS_CMP;
      end

      // pin input is asynchronous: two flops before any use
      ccp_edge u_pin (.sys_clk(sys_clk), .reset(reset), .async_in(input_pin[g]),
        .level(pin_lvl), .rise(pin_rise), .fall(pin_fall));

      // trigger source; pin-change is an event, so only its rise counts
      always_comb begin
        unique case (trig_r[g])
          2'h0: begin s_rise = pin_rise; s_fall = pin_fall; end
          2'h1: begin s_rise = cmp1_rise; s_fall = cmp1_fall; end
          2'h2: begin s_rise = cmp2_rise; s_fall = cmp2_fall; end
          default: begin s_rise = pc_rise; s_fall = 1'b0; end
        endcase
      end

      // capture/compare timer 1/3/5 by binding code
      always_comb begin
        unique case (tsel)
          2'h1: tval = timer_one;
          2'h2: tval = timer_three;
          default: tval = timer_five;
        endcase
      end

      // prescale restarts whenever the channel leaves capture
      always_ff @(posedge sys_clk) begin
        if (reset || cls != CCP_CLS_CAP) presc_r <= 4'h0;
        else if (s_rise) presc_r <= presc_r + 4'h1;
      end

      always_comb begin
        unique case (mode)
          CCP_M_CAP_ANY: cap_hit = s_rise | s_fall;
          CCP_M_CAP_FALL: cap_hit = s_fall;
          CCP_M_CAP_RISE: cap_hit = s_rise;
          CCP_M_CAP_R4: cap_hit = s_rise && presc_r[1:0] == CCP_PRESC_4[1:0];
          CCP_M_CAP_R16: cap_hit = s_rise && presc_r == CCP_PRESC_16;
          default: cap_hit = 1'b0;
        endcase
      end

      // match fires once per equal run; avoids repeat while timer holds
      assign match = cls == CCP_CLS_CMP && tval == val_r[g] && !match_seen_r;
      always_ff @(posedge sys_clk) begin
        if (reset) match_seen_r <= 1'b0;
        else match_seen_r <= cls == CCP_CLS_CMP && tval == val_r[g];
      end

      // width alignment of the value register
      assign width = ctrl_r[g][CCP_FMT_BIT] ? {val_r[g][15:8], val_r[g][7:6]}
                                             : val_r[g][9:0];
      ccp_pwm u_pwm (.sys_clk(sys_clk), .reset(reset), .run(cls == CCP_CLS_PWM),
        .tick(period_timer_tick[tsel - 2'h1]), .tmr_cnt(period_timer_count[tsel - 2'h1]),
        .tmr_low(period_timer_low[tsel - 2'h1]), .period(period_limit[tsel - 2'h1]),
        .duty(width), .pwm_out(pwm_lvl), .period_evt(pwm_evt));

      // status bits: channels first, then the two plain PWMs
      assign evt[g] = (cls == CCP_CLS_CAP && cap_hit) || match || pwm_evt;

      // output bit is never stored; reads show the live level
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          ctrl_r[g] <= CCP_CTRL_RST;
          trig_r[g] <= 2'h0;
        end else begin
          if (ctrl_wr) ctrl_r[g] <= {wb_dat_i[7], 2'h0, wb_dat_i[4:0]};
          if (wr && idx == i_trig) trig_r[g] <= wb_dat_i[1:0];
        end
      end

      // capture overrides a same-cycle software write
      always_ff @(posedge sys_clk) begin
        if (reset) val_r[g] <= 16'h0000;
        else if (cls == CCP_CLS_CAP && cap_hit) val_r[g] <= tval;
        else if (wr && idx == i_lo) val_r[g][7:0] <= wb_dat_i[7:0];
        else if (wr && idx == i_hi) val_r[g][15:8] <= wb_dat_i[7:0];
      end

      // pulse modes hold the output high for a single cycle
      always_ff @(posedge sys_clk) begin
        if (reset) pulse_r <= 1'b0;
        else pulse_r <= match && mode[3:1] == CCP_M_PULSE[3:1];
      end

      // set/clear result stays latched until disable or mode 0000
      always_ff @(posedge sys_clk) begin
        if (reset || !en || mode == CCP_M_OFF) ch_out_r[g] <= 1'b0;
        else if (cls == CCP_CLS_PWM) ch_out_r[g] <= pwm_lvl;
        else if (match) begin
          unique case (mode)
            CCP_M_SET: ch_out_r[g] <= 1'b1;
            CCP_M_CLR: ch_out_r[g] <= 1'b0;
            CCP_M_PULSE, CCP_M_PULSE_CLR: ch_out_r[g] <= 1'b1;
            default: ch_out_r[g] <= ~ch_out_r[g];
          endcase
        end else if (pulse_r && mode[3:1] == CCP_M_PULSE[3:1]) ch_out_r[g] <= 1'b0;
      end
    end
  endgenerate
  // one output flop per channel; PWM level arrives a cycle late
  assign channel_out = ch_out_r;

  // plain PWM channels on period timers 2/4/6
  generate
    for (g = 0; g < 2; g++) begin : g_pwm
      logic [1:0] psel;
      logic pevt;
      logic [1:0] pi;
      assign psel = bind_r[4 + 2*g +: 2];
      assign pi = psel - 2'h1;
      ccp_pwm u_p (.sys_clk(sys_clk), .reset(reset), .run(psel != CCP_TSEL_RSVD),
        .tick(period_timer_tick[pi]), .tmr_cnt(period_timer_count[pi]),
        .tmr_low(period_timer_low[pi]), .period(period_limit[pi]),
        .duty(pduty_r[g]), .pwm_out(pwm_out[g]), .period_evt(pevt));
      assign evt[2+g] = pevt;
    end
  endgenerate

  // timer clear pulses: codes 0001/1011 clear 1/3/5 on match, any period-timer wrap clears 2/4/6
  always_comb begin
    cc_clr_nxt = 3'h0;
    pt_clr_nxt = 3'h0;
    for (int c = 0; c < NCH; c++) begin
      if (g_ch[0].match && c == 0 && (ctrl_r[0][3:0] == CCP_M_TOG_CLR
          || ctrl_r[0][3:0] == CCP_M_PULSE_CLR))
        cc_clr_nxt[bind_r[1:0] - 2'h1] = 1'b1;
      if (g_ch[1].match && c == 1 && (ctrl_r[1][3:0] == CCP_M_TOG_CLR
          || ctrl_r[1][3:0] == CCP_M_PULSE_CLR))
        cc_clr_nxt[bind_r[3:2] - 2'h1] = 1'b1;
    end
    for (int t = 0; t < 3; t++) begin
      if (period_timer_tick[t] && period_timer_low[t] == 2'h3
          && period_timer_count[t] == period_limit[t])
        pt_clr_nxt[t] = 1'b1;
    end
  end
  assign cc_timer_clear = cc_clr_nxt;
  assign period_timer_clear = pt_clr_nxt;

  // read mux
  always_comb begin
    rd_ok = 1'b1;
    rd_nxt = 32'h0000_0000;
    unique case (idx)
      CCP_CH1_VAL_LO: rd_nxt[7:0] = val_r[0][7:0];
      CCP_CH1_VAL_HI: rd_nxt[7:0] = val_r[0][15:8];
      CCP_CH1_CTRL: rd_nxt[7:0] = {ctrl_r[0][7], 1'b0, ch_out_r[0], ctrl_r[0][4:0]};
      CCP_CH1_TRIG: rd_nxt[1:0] = trig_r[0];
      CCP_CH2_VAL_LO: rd_nxt[7:0] = val_r[1][7:0];
      CCP_CH2_VAL_HI: rd_nxt[7:0] = val_r[1][15:8];
      CCP_CH2_CTRL: rd_nxt[7:0] = {ctrl_r[1][7], 1'b0, ch_out_r[1], ctrl_r[1][4:0]};
      CCP_CH2_TRIG: rd_nxt[1:0] = trig_r[1];
      CCP_TMR_BIND: rd_nxt[7:0] = bind_r;
      CCP_IRQ_STAT: rd_nxt[3:0] = stat_r;
      CCP_IRQ_MASK: rd_nxt[3:0] = mask_r;
      CCP_PWM_DUTY3: rd_nxt[15:0] = {6'h00, pduty_r[0][1:0], pduty_r[0][9:2]};
      CCP_PWM_DUTY4: rd_nxt[15:0] = {6'h00, pduty_r[1][1:0], pduty_r[1][9:2]};
      default: rd_ok = 1'b0;
    endcase
  end

  // one-cycle ack; unmapped reads return zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= rd_ok ? rd_nxt : 32'h0000_0000;
    end
  end
endmodule // ccp_top
